// ---- hpoc_pkg.sv ----
package hpoc_pkg;
  // ----------------------------------------
  // Host port
  // ----------------------------------------
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam logic [10:0] CTRL_ADDR = 11'h000;
  localparam logic [10:0] IRQ_FIFO_ADDR = 11'h001;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int CTRL_ODE_BIT = 6;
  localparam int FIFO_VALID_BIT = 7;
  localparam logic [7:0] EMPTY_READ = 8'h00;
  // ----------------------------------------
  // Interrupt buffer
  // ----------------------------------------
  localparam int CHAN_W = 5;
  localparam int IRQ_BUF_DEPTH = 2;
  // ----------------------------------------
  // Serial streams
  // ----------------------------------------
  localparam int C4_FREQ_KHZ = 4096;
  localparam int BIT_RATE_KBPS = 2048;
  localparam int C4_PER_BIT = C4_FREQ_KHZ / BIT_RATE_KBPS;
  localparam int CHANNELS = 32;
  localparam int BITS_PER_CH = 8;
  localparam int C4_PER_FRAME = CHANNELS * BITS_PER_CH * C4_PER_BIT;
  localparam int C4_CNT_W = $clog2(C4_PER_FRAME);
  localparam int FMT_STABLE_EDGES = 8;
  // ----------------------------------------
  // Synchroniser reset image: strobes and frame pulse idle high
  // ----------------------------------------
  localparam logic [7:0] SYNC_RST = 8'h23;
  typedef enum logic [1:0] {HS_IDLE, HS_DATA, HS_ACK} hpoc_host_st_t;
endpackage

// ---- hpoc_buf.sv ----
`timescale 1ns/1ps
module hpoc_buf #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // Drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in,
  // Fill level
  output logic [$clog2(DEPTH):0] level_out
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [PW:0] cnt_q, cnt_d;
  logic push, pop;

  function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
    ptr_next = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready_out = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem_q[rd_q];
  assign level_out = cnt_q;
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data_in;
      wr_d = ptr_next(wr_q);
    end
    if (pop) begin
      rd_d = ptr_next(rd_q);
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  chk_buf_bounds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cnt_q <= (PW+1)'(DEPTH)) else $error("Buffer level beyond depth");
endmodule

// ---- hpoc_top.sv ----
`timescale 1ns/1ps
// How it works
// [RQ1] The interrupt request pin is pulled low while any channel event waits in the buffer.
// [RQ2] The interrupt request pin is released only after the host has read every waiting entry.
// [RQ3] The host must assert chip select to open the port before any register access.
// [RQ4] An access starts only while data strobe and chip select are both low together.
// [RQ5] The read/write input makes the port drive the data bus on a read and sample it on a write.
// [RQ6] The transfer acknowledge pin is pulled low once the data of the access is settled.
// [RQ7] Register data moves over one eight-bit two-way data bus.
// [RQ8] Eleven address lines select the register of each access.
// [RQ9] The drive enable pin is ANDed with bit 6 of the main control register.
// [RQ10] Both serial outputs drive only when pin and bit are high, else both float.
// [RQ11] The port 1 send output carries a 2.048 Mbps stream of 32 channels per frame.
// [RQ12] The port 2 receive output carries a 2.048 Mbps stream of 32 channels per frame.
// [RQ13] The port 2 send input takes a 2.048 Mbps stream of 32 channels per frame.
// [RQ14] The port 1 receive input takes a 2.048 Mbps stream of 32 channels per frame.
// [RQ15] The system supplies the 4.096 MHz shift clock used by all four streams.
// [RQ16] The frame pulse polarity is found automatically from its idle level.
// [RQ17] Acknowledge and data drive are released as soon as strobe or select goes high.
module hpoc_top (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic NRST_IN,
  // Host port
  input wire logic HOST_CS_N_IN,
  input wire logic DATA_STROBE_N_IN,
  input wire logic HOST_RW_IN,
  input wire logic [10:0] HOST_ADDRESS_BUS_IN,
  input wire logic [7:0] HOST_DATA_BUS_IN,
  output logic [7:0] HOST_DATA_BUS_OUT,
  output logic HOST_DATA_BUS_OE_N_OUT,
  output logic TRANSFER_ACK_N_OUT,
  output logic TRANSFER_ACK_OE_N_OUT,
  // Interrupts from the channels
  input wire logic EVT_VALID_IN,
  input wire logic [4:0] EVT_CHAN_IN,
  output logic EVT_READY_OUT,
  output logic IRQ_N_OUT,
  output logic IRQ_OE_N_OUT,
  // Serial streams
  input wire logic OUTPUT_DRIVE_ENABLE_IN,
  input wire logic SERIAL_SHIFT_CLOCK_IN,
  input wire logic FRAME_PULSE_IN,
  input wire logic RECV_DATA_IN,
  input wire logic SEND_DATA_IN,
  output logic SEND_DATA_OUT,
  output logic SEND_DATA_OE_N_OUT,
  output logic RECV_DATA_OUT,
  output logic RECV_DATA_OE_N_OUT
);
  localparam int I_CS = 0;
  localparam int I_DS = 1;
  localparam int I_RW = 2;
  localparam int I_ODE = 3;
  localparam int I_C4 = 4;
  localparam int I_FP = 5;
  localparam int I_RIN = 6;
  localparam int I_SIN = 7;
  localparam logic [hpoc_pkg::C4_CNT_W-1:0] C4_LAST =
    hpoc_pkg::C4_CNT_W'(hpoc_pkg::C4_PER_FRAME - 1);
  localparam logic [3:0] FMT_LAST = 4'(hpoc_pkg::FMT_STABLE_EDGES - 1);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_q;
  logic rst_n;
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // A change counts once stages two and three agree, which filters single-sample glitches
  logic [7:0] s1_q, s2_q, s3_q, flt_q;
  logic [7:0] s1_d, s2_d, s3_d, flt_d;
  always_comb begin
    s1_d = {SEND_DATA_IN, RECV_DATA_IN, FRAME_PULSE_IN, SERIAL_SHIFT_CLOCK_IN,
            OUTPUT_DRIVE_ENABLE_IN, HOST_RW_IN, DATA_STROBE_N_IN, HOST_CS_N_IN};
    s2_d = s1_q;
    s3_d = s2_q;
    flt_d = (s2_q & ~(s2_q ^ s3_q)) | (flt_q & (s2_q ^ s3_q));
  end
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= hpoc_pkg::SYNC_RST;
      s2_q <= hpoc_pkg::SYNC_RST;
      s3_q <= hpoc_pkg::SYNC_RST;
      flt_q <= hpoc_pkg::SYNC_RST;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      flt_q <= flt_d;
    end
  end

  // ----------------------------------------
  // Interrupt buffer
  // ----------------------------------------
  logic buf_in_valid, buf_in_ready, buf_out_valid, buf_pop;
  logic [hpoc_pkg::CHAN_W-1:0] buf_out_chan;
  logic [$clog2(hpoc_pkg::IRQ_BUF_DEPTH):0] buf_level, lvl_next;
  logic evt_ready_q, evt_ready_d, irq_oe_n_q, irq_oe_n_d;

  assign buf_in_valid = EVT_VALID_IN & evt_ready_q;
  hpoc_buf #(.WIDTH(hpoc_pkg::CHAN_W), .DEPTH(hpoc_pkg::IRQ_BUF_DEPTH)) u_irq_buf (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(rst_n),
    .in_valid_in(buf_in_valid),
    .in_data_in(EVT_CHAN_IN),
    .in_ready_out(buf_in_ready),
    .out_valid_out(buf_out_valid),
    .out_data_out(buf_out_chan),
    .out_ready_in(buf_pop),
    .level_out(buf_level)
  );

  always_comb begin
    lvl_next = buf_level + (buf_in_valid & buf_in_ready) - (buf_pop & buf_out_valid);
    // Ready is registered, so it looks one word ahead to never offer a full buffer
    evt_ready_d = (lvl_next < ($clog2(hpoc_pkg::IRQ_BUF_DEPTH)+1)'(hpoc_pkg::IRQ_BUF_DEPTH));
    irq_oe_n_d = !buf_out_valid; // [RQ1] [RQ2]
  end
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      evt_ready_q <= 1'b0;
      irq_oe_n_q <= 1'b1;
    end else begin
      evt_ready_q <= evt_ready_d;
      irq_oe_n_q <= irq_oe_n_d;
    end
  end

  // ----------------------------------------
  // Host port
  // ----------------------------------------
  hpoc_pkg::hpoc_host_st_t st_q, st_d;
  logic [7:0] ctrl_q, ctrl_d, rdata_q, rdata_d;
  logic data_oe_n_q, data_oe_n_d, ack_oe_n_q, ack_oe_n_d;
  logic sel, is_read;

  // Address and data are not synchronised: the host holds them stable around the strobe
  assign sel = !flt_q[I_CS] && !flt_q[I_DS]; // [RQ3] [RQ4]
  assign is_read = flt_q[I_RW];
  assign buf_pop = (st_q == hpoc_pkg::HS_IDLE) && sel && is_read &&
                   (HOST_ADDRESS_BUS_IN == hpoc_pkg::IRQ_FIFO_ADDR); // [RQ2] [RQ8]

  always_comb begin
    st_d = st_q;
    ctrl_d = ctrl_q;
    rdata_d = rdata_q;
    data_oe_n_d = data_oe_n_q;
    ack_oe_n_d = ack_oe_n_q;
    case (st_q)
      hpoc_pkg::HS_IDLE: begin
        if (sel) begin
          st_d = hpoc_pkg::HS_DATA;
          data_oe_n_d = !is_read; // [RQ5] [RQ7]
          rdata_d = hpoc_pkg::EMPTY_READ;
          if (is_read && HOST_ADDRESS_BUS_IN == hpoc_pkg::CTRL_ADDR) begin // [RQ8]
            rdata_d = ctrl_q;
          end else if (buf_pop && buf_out_valid) begin
            rdata_d = 8'(buf_out_chan);
            rdata_d[hpoc_pkg::FIFO_VALID_BIT] = 1'b1;
          end else if (!is_read && HOST_ADDRESS_BUS_IN == hpoc_pkg::CTRL_ADDR) begin
            ctrl_d = HOST_DATA_BUS_IN; // [RQ5]
          end
        end
      end
      hpoc_pkg::HS_DATA: begin
        st_d = hpoc_pkg::HS_ACK;
        ack_oe_n_d = 1'b0; // [RQ6]
      end
      hpoc_pkg::HS_ACK: begin
        if (!sel) begin
          st_d = hpoc_pkg::HS_IDLE;
          ack_oe_n_d = 1'b1; // [RQ17]
          data_oe_n_d = 1'b1;
        end
      end
      default: begin
        st_d = hpoc_pkg::HS_IDLE;
        ack_oe_n_d = 1'b1;
        data_oe_n_d = 1'b1;
      end
    endcase
  end
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= hpoc_pkg::HS_IDLE;
      ctrl_q <= hpoc_pkg::CTRL_RST;
      rdata_q <= hpoc_pkg::EMPTY_READ;
      data_oe_n_q <= 1'b1;
      ack_oe_n_q <= 1'b1;
    end else begin
      st_q <= st_d;
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
      data_oe_n_q <= data_oe_n_d;
      ack_oe_n_q <= ack_oe_n_d;
    end
  end

  // ----------------------------------------
  // Serial streams
  // ----------------------------------------
  logic c4_prev_q, c4_prev_d, fp_last_q, fp_last_d, fp_idle_q, fp_idle_d;
  logic fp_act_q, fp_act_d, rin_s_q, rin_s_d, sin_s_q, sin_s_d;
  logic sout_q, sout_d, rout_q, rout_d, ser_oe_n_q, ser_oe_n_d;
  logic [3:0] fmt_cnt_q, fmt_cnt_d;
  logic [hpoc_pkg::C4_CNT_W-1:0] c4cnt_q, c4cnt_d;
  logic c4_fall, c4_rise, fp_act, frame_start;

  assign c4_fall = c4_prev_q && !flt_q[I_C4]; // [RQ15]
  assign c4_rise = !c4_prev_q && flt_q[I_C4];
  assign fp_act = flt_q[I_FP] ^ fp_idle_q; // [RQ16]
  assign frame_start = c4_fall && fp_act && !fp_act_q;

  always_comb begin
    c4_prev_d = flt_q[I_C4];
    fp_last_d = fp_last_q;
    fp_idle_d = fp_idle_q;
    fp_act_d = fp_act_q;
    fmt_cnt_d = fmt_cnt_q;
    c4cnt_d = c4cnt_q;
    rin_s_d = rin_s_q;
    sin_s_d = sin_s_q;
    sout_d = sout_q;
    rout_d = rout_q;
    ser_oe_n_d = !(flt_q[I_ODE] && ctrl_q[hpoc_pkg::CTRL_ODE_BIT]); // [RQ9] [RQ10]
    if (c4_fall) begin
      // Only the idle level lasts long; the pulse spans at most two clocks
      fp_last_d = flt_q[I_FP];
      fp_act_d = fp_act;
      if (flt_q[I_FP] != fp_last_q) begin
        fmt_cnt_d = 4'h0;
      end else if (fmt_cnt_q != FMT_LAST) begin
        fmt_cnt_d = fmt_cnt_q + 4'h1;
      end else begin
        fp_idle_d = flt_q[I_FP]; // [RQ16]
      end
      if (frame_start) begin
        c4cnt_d = '0;
      end else if (c4cnt_q == C4_LAST) begin
        c4cnt_d = '0; // [RQ11] [RQ12]
      end else begin
        c4cnt_d = c4cnt_q + 1'b1;
      end
      if (!c4cnt_d[0]) begin
        sout_d = sin_s_q; // [RQ11]
        rout_d = rin_s_q; // [RQ12]
      end
    end
    if (c4_rise && c4cnt_q[0]) begin
      rin_s_d = flt_q[I_RIN]; // [RQ14]
      sin_s_d = flt_q[I_SIN]; // [RQ13]
    end
  end
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      c4_prev_q <= 1'b0;
      fp_last_q <= 1'b1;
      fp_idle_q <= 1'b1;
      fp_act_q <= 1'b0;
      fmt_cnt_q <= 4'h0;
      c4cnt_q <= '0;
      rin_s_q <= 1'b1;
      sin_s_q <= 1'b1;
      sout_q <= 1'b1;
      rout_q <= 1'b1;
      ser_oe_n_q <= 1'b1;
    end else begin
      c4_prev_q <= c4_prev_d;
      fp_last_q <= fp_last_d;
      fp_idle_q <= fp_idle_d;
      fp_act_q <= fp_act_d;
      fmt_cnt_q <= fmt_cnt_d;
      c4cnt_q <= c4cnt_d;
      rin_s_q <= rin_s_d;
      sin_s_q <= sin_s_d;
      sout_q <= sout_d;
      rout_q <= rout_d;
      ser_oe_n_q <= ser_oe_n_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign HOST_DATA_BUS_OUT = rdata_q;
  assign HOST_DATA_BUS_OE_N_OUT = data_oe_n_q;
  assign TRANSFER_ACK_N_OUT = rst_q[0] & 1'b0;
  assign TRANSFER_ACK_OE_N_OUT = ack_oe_n_q;
  assign EVT_READY_OUT = evt_ready_q;
  assign IRQ_N_OUT = rst_q[0] & 1'b0;
  assign IRQ_OE_N_OUT = irq_oe_n_q;
  assign SEND_DATA_OUT = sout_q;
  assign SEND_DATA_OE_N_OUT = ser_oe_n_q;
  assign RECV_DATA_OUT = rout_q;
  assign RECV_DATA_OE_N_OUT = ser_oe_n_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!rst_n);

  chk_irq_pending: assert property (EVT_VALID_IN && EVT_READY_OUT |-> ##2 !IRQ_OE_N_OUT) // [RQ1]
    else $error("Interrupt not pulled low after a channel event");
  chk_irq_release: assert property ($rose(IRQ_OE_N_OUT) |-> $past(buf_pop && buf_out_valid, 2)) // [RQ2]
    else $error("Interrupt released without the last entry read");
  chk_access_gate: assert property ($rose(st_q == hpoc_pkg::HS_DATA) |-> $past(sel)) // [RQ4]
    else $error("Access started without strobe and select");
  chk_read_drive: assert property (st_q == hpoc_pkg::HS_IDLE && sel && is_read
    |=> !HOST_DATA_BUS_OE_N_OUT ##1 !HOST_DATA_BUS_OE_N_OUT) // [RQ5]
    else $error("Read data not driven");
  chk_write_float: assert property (st_q == hpoc_pkg::HS_IDLE && sel && !is_read
    |=> HOST_DATA_BUS_OE_N_OUT) // [RQ5]
    else $error("Data bus driven on a write");
  chk_ack_after_data: assert property (st_q == hpoc_pkg::HS_IDLE && sel
    |=> TRANSFER_ACK_OE_N_OUT ##1 !TRANSFER_ACK_OE_N_OUT) // [RQ6]
    else $error("Acknowledge not given two cycles after access start");
  chk_ack_release: assert property (st_q == hpoc_pkg::HS_ACK && !sel
    |=> TRANSFER_ACK_OE_N_OUT && HOST_DATA_BUS_OE_N_OUT) // [RQ17]
    else $error("Acknowledge not released after strobe release");
  chk_ctrl_write: assert property (st_q == hpoc_pkg::HS_IDLE && sel && !is_read &&
    HOST_ADDRESS_BUS_IN == hpoc_pkg::CTRL_ADDR |=> ctrl_q == $past(HOST_DATA_BUS_IN)) // [RQ8]
    else $error("Control write lost");
  chk_ode_gate: assert property (!(flt_q[I_ODE] && ctrl_q[hpoc_pkg::CTRL_ODE_BIT])
    |=> SEND_DATA_OE_N_OUT && RECV_DATA_OE_N_OUT) // [RQ9] [RQ10]
    else $error("Serial output driven while disabled");
  chk_ode_on: assert property (flt_q[I_ODE] && ctrl_q[hpoc_pkg::CTRL_ODE_BIT]
    |=> !SEND_DATA_OE_N_OUT && !RECV_DATA_OE_N_OUT) // [RQ10]
    else $error("Serial output floating while enabled");
  chk_frame_wrap: assert property (c4_fall && !frame_start && c4cnt_q == C4_LAST
    |=> c4cnt_q == '0) // [RQ11] [RQ12]
    else $error("Frame length not 32 channels");

  cov_fifo_read: cover property (buf_pop && buf_out_valid);
  cov_ctrl_write: cover property (st_q == hpoc_pkg::HS_IDLE && sel && !is_read);
  cov_frame_start: cover property (frame_start);
  cov_outputs_on: cover property (!SEND_DATA_OE_N_OUT);
endmodule

// ---- hpoc_host_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Host processor on the byte-wide port
// ----------------------------------------
module hpoc_host_model (
  // Clock
  input wire logic clk_in,
  // Strobes and address
  output logic cs_n_out,
  output logic ds_n_out,
  output logic rw_out,
  output logic [10:0] addr_out,
  // Data and answer
  output logic [7:0] data_out,
  input wire logic [7:0] bus_in,
  input wire logic dev_oe_n_in,
  input wire logic ack_n_in
);
  initial begin
    cs_n_out = 1'b1;
    ds_n_out = 1'b1;
    rw_out = 1'b1;
    addr_out = 11'h000;
    data_out = 8'h00;
  end

  // One access; bad marks a lost answer or the device driving during a write
  task automatic acc(input logic rd, input logic [10:0] a, input logic [7:0] wd,
                     output logic [7:0] rv, output logic bad);
    int n;
    bad = 1'b0;
    @(posedge clk_in);
    #1;
    cs_n_out = 1'b0;
    ds_n_out = 1'b0;
    rw_out = rd;
    addr_out = a;
    data_out = rd ? ~data_out : wd;
    for (n = 0; n < 20 && ack_n_in !== 1'b0; n++) begin
      @(posedge clk_in);
      if (!rd && dev_oe_n_in !== 1'b1) bad = 1'b1;
    end
    rv = bus_in;
    if (n == 20) bad = 1'b1;
    #1;
    cs_n_out = 1'b1;
    ds_n_out = 1'b1;
    // Released lines must not keep the old value alive
    addr_out = ~a;
    data_out = ~data_out;
    for (n = 0; n < 20 && ack_n_in !== 1'b1; n++) begin
      @(posedge clk_in);
    end
    if (n == 20) bad = 1'b1;
  endtask

  // Only one of the two strobes low: nothing may answer
  task automatic half(input logic use_cs, output logic bad);
    bad = 1'b0;
    @(posedge clk_in);
    #1;
    rw_out = 1'b1;
    cs_n_out = ~use_cs;
    ds_n_out = use_cs;
    repeat (10) begin
      @(posedge clk_in);
      if (ack_n_in !== 1'b1 || dev_oe_n_in !== 1'b1) bad = 1'b1;
    end
    #1;
    cs_n_out = 1'b1;
    ds_n_out = 1'b1;
  endtask
endmodule

// ---- tb_host_port_and_pcm_output_control.sv ----
`timescale 1ns/1ps
module tb_host_port_and_pcm_output_control;
  logic clk, nrst, lclk, output_drive_enable, fp, rin, sin, evt_v;
  logic [4:0] evt_ch;
  logic cs_n, ds_n, rw, doe_n, ack_n, ack_oe_n, rdy, irq_n, irq_oe_n;
  logic s_out, s_oe_n, r_out, r_oe_n;
  logic [10:0] addr;
  logic [7:0] hdat, ddat;
  int err_count, check_count;
  // Pull-up on the acknowledge line; bus shows whoever drives it
  wire ack_w = ack_oe_n ? 1'b1 : ack_n;
  wire irq_w = irq_oe_n ? 1'b1 : irq_n;
  wire [7:0] bus_w = doe_n ? hdat : ddat;

  hpoc_top uut (.SYS_CLK_IN(clk), .NRST_IN(nrst), .HOST_CS_N_IN(cs_n),
    .DATA_STROBE_N_IN(ds_n), .HOST_RW_IN(rw), .HOST_ADDRESS_BUS_IN(addr),
    .HOST_DATA_BUS_IN(bus_w), .HOST_DATA_BUS_OUT(ddat), .HOST_DATA_BUS_OE_N_OUT(doe_n),
    .TRANSFER_ACK_N_OUT(ack_n), .TRANSFER_ACK_OE_N_OUT(ack_oe_n), .EVT_VALID_IN(evt_v),
    .EVT_CHAN_IN(evt_ch), .EVT_READY_OUT(rdy), .IRQ_N_OUT(irq_n), .IRQ_OE_N_OUT(irq_oe_n),
    .OUTPUT_DRIVE_ENABLE_IN(output_drive_enable), .SERIAL_SHIFT_CLOCK_IN(lclk), .FRAME_PULSE_IN(fp),
    .RECV_DATA_IN(rin), .SEND_DATA_IN(sin), .SEND_DATA_OUT(s_out),
    .SEND_DATA_OE_N_OUT(s_oe_n), .RECV_DATA_OUT(r_out), .RECV_DATA_OE_N_OUT(r_oe_n));
  hpoc_host_model host (.clk_in(clk), .cs_n_out(cs_n), .ds_n_out(ds_n), .rw_out(rw),
    .addr_out(addr), .data_out(hdat), .bus_in(bus_w), .dev_oe_n_in(doe_n),
    .ack_n_in(ack_w));

  // ----------------------------------------
  // Clocks and shared tasks
  // ----------------------------------------
  always #25 clk = ~clk;
  initial begin
    lclk = 1'b0;
    #13;
    forever #200 lclk = ~lclk;
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task rw_reg(input logic rd, input logic [10:0] a, input logic [7:0] wd,
              output logic [7:0] rv);
    logic bad;
    host.acc(rd, a, wd, rv, bad);
    chk({7'h00, bad}, 8'h00);
  endtask

  task push(input logic [4:0] ch);
    int n;
    @(posedge clk);
    #1;
    evt_v = 1'b1;
    evt_ch = ch;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 10);
    chk({7'h00, rdy}, 8'h01);
    #1;
    evt_v = 1'b0;
  endtask

  function automatic logic pat(input int k);
    return k[0] ^ k[2] ^ k[4];
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    logic [7:0] v;
    chk({7'h00, s_oe_n}, 8'h01);
    chk({7'h00, irq_w}, 8'h01);
    rw_reg(1'b1, hpoc_pkg::CTRL_ADDR, 8'h00, v);
    chk(v, hpoc_pkg::CTRL_RST);
    rw_reg(1'b0, hpoc_pkg::CTRL_ADDR, 8'h40, v);
    rw_reg(1'b0, hpoc_pkg::CTRL_ADDR | 11'h400, 8'h00, v);
    rw_reg(1'b1, hpoc_pkg::CTRL_ADDR, 8'h00, v);
    chk(v, 8'h40);
    rw_reg(1'b1, 11'h7ff, 8'h55, v);
    chk(v, 8'h00);
  endtask

  task t_strobe;
    logic bad;
    host.half(1'b1, bad);
    chk({7'h00, bad}, 8'h00);
    host.half(1'b0, bad);
    chk({7'h00, bad}, 8'h00);
  endtask

  task t_ode;
    logic [7:0] v;
    int i;
    for (i = 0; i < 4; i++) begin
      rw_reg(1'b0, hpoc_pkg::CTRL_ADDR, {1'b0, i[1], 6'h00}, v);
      @(posedge clk);
      #1;
      output_drive_enable = i[0];
      repeat (8) @(posedge clk);
      #1;
      chk({7'h00, s_oe_n}, {7'h00, ~(i[0] & i[1])});
      chk({7'h00, r_oe_n}, {7'h00, ~(i[0] & i[1])});
    end
  endtask

  task t_irq;
    logic [7:0] v;
    push(5'd5);
    chk({7'h00, irq_w}, 8'h01);
    @(posedge clk);
    #1;
    chk({7'h00, irq_w}, 8'h00);
    @(posedge clk);
    #1;
    chk({7'h00, irq_w}, 8'h00);
    push(5'd17);
    // Buffer full: a third event must wait, not be taken
    @(posedge clk);
    #1;
    evt_v = 1'b1;
    evt_ch = 5'd9;
    repeat (4) begin
      @(posedge clk);
      chk({7'h00, rdy}, 8'h00);
    end
    #1;
    evt_v = 1'b0;
    rw_reg(1'b1, hpoc_pkg::IRQ_FIFO_ADDR, 8'h00, v);
    chk(v, {1'b1, 2'b00, 5'd5});
    chk({7'h00, irq_w}, 8'h00);
    rw_reg(1'b1, hpoc_pkg::IRQ_FIFO_ADDR, 8'h00, v);
    chk(v, {1'b1, 2'b00, 5'd17});
    chk({7'h00, irq_w}, 8'h01);
    rw_reg(1'b1, hpoc_pkg::IRQ_FIFO_ADDR, 8'h00, v);
    chk(v, 8'h00);
  endtask

  // Two frames of looped traffic; idle is the resting level of the frame pulse
  task t_serial(input logic idle);
    int n;
    int k;
    chk({7'h00, s_oe_n}, 8'h00);
    @(posedge lclk);
    #1;
    fp = idle;
    repeat (16) @(negedge lclk);
    for (n = 0; n < 1028; n++) begin
      @(posedge lclk);
      #1;
      fp = (n % 512 == 0) ? ~idle : idle;
      @(negedge lclk);
      #1;
      if (n % 2 == 0) begin
        rin = pat(n / 2);
        sin = ~pat(n / 2);
      end else if (n >= 5) begin
        k = (n - 3) / 2;
        chk({7'h00, r_out}, {7'h00, pat(k)});
        chk({7'h00, s_out}, {7'h00, ~pat(k)});
      end
    end
  endtask

  // ----------------------------------------
  // Sequence and verdict
  // ----------------------------------------
  task test_done;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    err_count++;
    test_done;
  end

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    output_drive_enable = 1'b0;
    fp = 1'b1;
    rin = 1'b1;
    sin = 1'b1;
    evt_v = 1'b0;
    evt_ch = 5'h00;
    err_count = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (6) @(posedge clk);
    t_regs;
    t_strobe;
    t_ode;
    t_irq;
    t_serial(1'b1);
    t_serial(1'b0);
    test_done;
  end
endmodule
